// File: common/ssc_pkg.sv
// Shared constants and types of the sample stream control block
package ssc_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [3:0]  IDX_STREAM_CFG   = 4'h2;
    localparam logic [3:0]  IDX_CHANNEL_CFG  = 4'h3;
    localparam logic [3:0]  IDX_STATUS       = 4'h4;
    localparam int          ADDR_LSB         = 2;
    localparam int          ADDR_W           = 6;
    localparam logic [31:0] STREAM_CFG_RESET = 32'h0EAF_A1DC;
    localparam logic [31:0] CHANNEL_RESET    = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int BIT_PATH_EN    = 11;
    localparam int BIT_GO         = 10;
    localparam int BIT_HALT       = 9;
    localparam int BIT_SEL_HI     = 5;
    localparam int BIT_SEL_LO     = 4;
    localparam int BIT_COUNT_INS  = 3;
    localparam int BIT_PULSE_ALL  = 2;
    localparam int BIT_WORD_PULSE = 1;
    localparam int BIT_CLEAR      = 0;
    localparam int BIT_QUAD_EN    = 0;
    localparam int BIT_ST_STREAM  = 0;
    localparam int BIT_ST_PATH    = 1;

    // ---------------------------------------------------------------
    // Stream encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] SEL_I_ONLY  = 2'h1;
    localparam logic [1:0] SEL_I_AND_Q = 2'h3;
    localparam int         WORD_BITS   = 16;
    localparam int         LANES       = 4;
    localparam logic [2:0] WORDS_I     = 3'h2;
    localparam logic [2:0] WORDS_IQ    = 3'h4;

    typedef struct packed {
        logic       path_en;
        logic       pulse_all;
        logic       word_pulse;
        logic       count_ins;
        logic [1:0] bit_sel;
        logic       quad_en;
    } ssc_cfg_type;

    typedef struct packed {
        logic clear;
        logic halt;
        logic go;
    } ssc_evt_type;
endpackage

// File: hw/ssc_sync.sv
// Two-stage synchroniser for levels and event toggles
module ssc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// File: hw/ssc_stream_control.sv
// Sample stream control: AXI4-Lite registers and link-side serializer
// Operation
// - Path enable bit inserts the streaming interface; clear bypasses it
// - Rising edge of go bit starts streaming and enables clock and sync outputs
// - Rising edge of halt bit stops streaming and disables clock, word and frame sync outputs
// - Bit select 1 sends I MSB/LSB; 3 adds Q MSB/LSB when quadrature enabled; 0,2 reserved
// - Frame-count insert puts frame number at start of each frame
// - Pulse-always gives time-sync whenever path enabled, else only while streaming
// - Word pulse enable marks start of each 16-bit data word on word sync
// - Writing clear bit resets all streaming counters once it has crossed to the link clock
// - Quadrature enable 0 gives I only, 1 gives I and Q when bit select is 3
module ssc_stream_control (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        link_clk,
    input  wire logic [1:0]  sample_i,
    input  wire logic [1:0]  sample_q,
    input  wire logic        sample_valid,
    output logic [3:0]       bypass_sample,
    output logic             stream_clock_enable,
    output logic             stream_data,
    output logic             word_sync_out,
    output logic             frame_sync_out,
    output logic             time_sync_out
);
    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    logic [31:0] stream_and_filter_config;
    logic [31:0] channel_config;
    logic [ssc_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_held;
    logic        w_held;
    logic        evt_go_t;
    logic        evt_halt_t;
    logic        evt_clear_t;
    logic [1:0]  status_sync;

    function automatic logic [31:0] ssc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] ssc_index(input logic [ssc_pkg::ADDR_W-1:0] a);
        return a[ssc_pkg::ADDR_W-1:ssc_pkg::ADDR_LSB];
    endfunction

    wire         aw_take    = s_axi_awvalid && s_axi_awready;
    wire         w_take     = s_axi_wvalid && s_axi_wready;
    wire         ar_take    = s_axi_arvalid && s_axi_arready;
    wire         do_write   = aw_held && w_held && !s_axi_bvalid;
    wire [3:0]   wr_index   = ssc_index(aw_addr);
    wire [3:0]   rd_index   = ssc_index(s_axi_araddr);
    wire         wr_cfg     = do_write && (wr_index == ssc_pkg::IDX_STREAM_CFG);
    wire         wr_chan    = do_write && (wr_index == ssc_pkg::IDX_CHANNEL_CFG);
    wire         wr_mapped  = wr_cfg || wr_chan;
    wire [31:0]  cfg_merged = ssc_merge(stream_and_filter_config, w_data, w_strb);
    // Clear is a command; it never stays set in the register
    wire [31:0]  cfg_stored = {cfg_merged[31:1], 1'b0};
    wire         go_rise    = wr_cfg && cfg_merged[ssc_pkg::BIT_GO]
                              && !stream_and_filter_config[ssc_pkg::BIT_GO];
    wire         halt_rise  = wr_cfg && cfg_merged[ssc_pkg::BIT_HALT]
                              && !stream_and_filter_config[ssc_pkg::BIT_HALT];
    wire         clear_cmd  = wr_cfg && cfg_merged[ssc_pkg::BIT_CLEAR];
    wire [31:0]  status_word = {30'h0000_0000, status_sync};
    wire         rd_mapped  = (rd_index == ssc_pkg::IDX_STREAM_CFG)
                              || (rd_index == ssc_pkg::IDX_CHANNEL_CFG)
                              || (rd_index == ssc_pkg::IDX_STATUS);
    wire [31:0]  rd_value   = (rd_index == ssc_pkg::IDX_STREAM_CFG) ? stream_and_filter_config :
                              (rd_index == ssc_pkg::IDX_CHANNEL_CFG) ? channel_config :
                              (rd_index == ssc_pkg::IDX_STATUS) ? status_word : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
        end else begin
            if (aw_take) begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ssc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? ssc_pkg::RESP_OKAY : ssc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stream_and_filter_config <= ssc_pkg::STREAM_CFG_RESET;
            channel_config           <= ssc_pkg::CHANNEL_RESET;
        end else begin
            if (wr_cfg) begin
                stream_and_filter_config <= cfg_stored;
            end
            if (wr_chan) begin
                channel_config <= ssc_merge(channel_config, w_data, w_strb);
            end
        end
    end

    // Commands cross as toggles so a short pulse cannot be missed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_go_t    <= 1'b0;
            evt_halt_t  <= 1'b0;
            evt_clear_t <= 1'b0;
        end else begin
            evt_go_t    <= evt_go_t ^ go_rise;
            evt_halt_t  <= evt_halt_t ^ halt_rise;
            evt_clear_t <= evt_clear_t ^ clear_cmd;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= ssc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_value;
            s_axi_rresp   <= rd_mapped ? ssc_pkg::RESP_OKAY : ssc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Domain crossing
    // ---------------------------------------------------------------
    logic [1:0] link_rst_pipe;
    wire        link_resetn = link_rst_pipe[1];
    ssc_pkg::ssc_cfg_type cfg_a;
    ssc_pkg::ssc_cfg_type cfg;
    ssc_pkg::ssc_evt_type evt_a;
    ssc_pkg::ssc_evt_type evt_s;
    ssc_pkg::ssc_evt_type evt_prev;
    logic       streaming;
    logic [1:0] status_link;

    always_ff @(posedge link_clk) begin
        link_rst_pipe <= {link_rst_pipe[0], aresetn};
    end

    // Configuration is quasi-static; change it only while halted
    assign cfg_a.path_en    = stream_and_filter_config[ssc_pkg::BIT_PATH_EN];
    assign cfg_a.pulse_all  = stream_and_filter_config[ssc_pkg::BIT_PULSE_ALL];
    assign cfg_a.word_pulse = stream_and_filter_config[ssc_pkg::BIT_WORD_PULSE];
    assign cfg_a.count_ins  = stream_and_filter_config[ssc_pkg::BIT_COUNT_INS];
    assign cfg_a.bit_sel    = stream_and_filter_config[ssc_pkg::BIT_SEL_HI:ssc_pkg::BIT_SEL_LO];
    assign cfg_a.quad_en    = channel_config[ssc_pkg::BIT_QUAD_EN];
    assign evt_a            = '{clear: evt_clear_t, halt: evt_halt_t, go: evt_go_t};
    assign status_link      = {cfg.path_en, streaming};

    ssc_sync #(.WIDTH($bits(ssc_pkg::ssc_cfg_type))) u_cfg_sync (
        .clk      (link_clk),
        .resetn   (link_resetn),
        .async_in (cfg_a),
        .sync_out (cfg)
    );

    ssc_sync #(.WIDTH($bits(ssc_pkg::ssc_evt_type))) u_evt_sync (
        .clk      (link_clk),
        .resetn   (link_resetn),
        .async_in (evt_a),
        .sync_out (evt_s)
    );

    ssc_sync #(.WIDTH(2)) u_status_sync (
        .clk      (aclk),
        .resetn   (aresetn),
        .async_in (status_link),
        .sync_out (status_sync)
    );

    // ---------------------------------------------------------------
    // Link side: capture
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_STAMP, ST_DATA} ssc_state_type;
    ssc_state_type state;
    logic [ssc_pkg::LANES-1:0][ssc_pkg::WORD_BITS-1:0] cap_word;
    logic [ssc_pkg::LANES-1:0][ssc_pkg::WORD_BITS-1:0] hold_word;
    logic [3:0]  cap_cnt;
    logic        frame_ready;
    logic [15:0] frame_num;
    logic [3:0]  bit_cnt;
    logic [1:0]  word_idx;

    wire go_evt    = evt_s.go ^ evt_prev.go;
    wire halt_evt  = evt_s.halt ^ evt_prev.halt;
    wire clear_evt = evt_s.clear ^ evt_prev.clear;
    wire [3:0] lane_bit = {sample_q[0], sample_q[1], sample_i[0], sample_i[1]};
    wire cap_en    = sample_valid && cfg.path_en;
    wire cap_wrap  = cap_en && (cap_cnt == 4'hF);
    wire start_frm = (state == ST_IDLE) && frame_ready && streaming;
    // Reserved selects and I-only channel mode both fall back to I words
    wire [2:0] n_words = ((cfg.bit_sel == ssc_pkg::SEL_I_AND_Q) && cfg.quad_en)
                         ? ssc_pkg::WORDS_IQ : ssc_pkg::WORDS_I;
    wire last_bit  = (bit_cnt == 4'hF);
    wire last_word = ({1'b0, word_idx} == n_words - 3'h1);

    for (genvar k = 0; k < ssc_pkg::LANES; k++) begin : g_lane
        always_ff @(posedge link_clk) begin
            if (!link_resetn || clear_evt) begin
                cap_word[k] <= '0;
            end else if (cap_en) begin
                cap_word[k] <= {cap_word[k][ssc_pkg::WORD_BITS-2:0], lane_bit[k]};
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_resetn) begin
            evt_prev <= '0;
        end else begin
            evt_prev <= evt_s;
        end
    end

    // Halt wins over a go arriving in the same cycle
    always_ff @(posedge link_clk) begin
        if (!link_resetn) begin
            streaming <= 1'b0;
        end else if (halt_evt) begin
            streaming <= 1'b0;
        end else if (go_evt) begin
            streaming <= 1'b1;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_resetn || clear_evt) begin
            cap_cnt     <= '0;
            frame_ready <= 1'b0;
            hold_word   <= '0;
        end else begin
            if (cap_en) begin
                cap_cnt <= cap_cnt + 4'h1;
            end
            if (cap_wrap) begin
                frame_ready <= 1'b1;
                hold_word   <= {cap_word[3][14:0], lane_bit[3], cap_word[2][14:0], lane_bit[2],
                                cap_word[1][14:0], lane_bit[1], cap_word[0][14:0], lane_bit[0]};
            end else if (start_frm) begin
                frame_ready <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Link side: serializer
    // ---------------------------------------------------------------
    // A block that completes mid-frame overwrites the held one; no queue
    always_ff @(posedge link_clk) begin
        if (!link_resetn || clear_evt || !streaming) begin
            state    <= ST_IDLE;
            bit_cnt  <= '0;
            word_idx <= '0;
            if (!link_resetn || clear_evt) begin
                frame_num <= '0;
            end
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_frm) begin
                        state   <= cfg.count_ins ? ST_STAMP : ST_DATA;
                        bit_cnt <= '0;
                    end
                end
                ST_STAMP: begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (last_bit) begin
                        state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (last_bit) begin
                        word_idx <= word_idx + 2'h1;
                        if (last_word) begin
                            state     <= ST_IDLE;
                            word_idx  <= '0;
                            frame_num <= frame_num + 16'h0001;
                        end
                    end
                end
            endcase
        end
    end

    wire data_bit  = (state == ST_STAMP) ? frame_num[4'hF - bit_cnt] :
                     (state == ST_DATA) ? hold_word[word_idx][4'hF - bit_cnt] : 1'b0;
    wire frm_first = (state == ST_STAMP || state == ST_DATA) && (bit_cnt == 4'h0)
                     && (word_idx == 2'h0) && (state == ST_STAMP || !cfg.count_ins);
    wire word_first = (state == ST_DATA) && (bit_cnt == 4'h0);
    wire pulse_ok  = cfg.path_en && (cfg.pulse_all || streaming);

    always_ff @(posedge link_clk) begin
        if (!link_resetn) begin
            stream_clock_enable <= 1'b0;
            stream_data         <= 1'b0;
            word_sync_out       <= 1'b0;
            frame_sync_out      <= 1'b0;
            time_sync_out       <= 1'b0;
            bypass_sample       <= '0;
        end else begin
            stream_clock_enable <= streaming;
            stream_data         <= streaming && data_bit;
            word_sync_out       <= streaming && cfg.word_pulse && word_first;
            frame_sync_out      <= streaming && frm_first;
            time_sync_out       <= pulse_ok && cap_wrap;
            bypass_sample       <= cfg.path_en ? 4'h0 : lane_bit;
        end
    end
endmodule

// File: dv/ssc_stream_control_asserts.sv
// Port assertions of the sample stream control block
module ssc_stream_control_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        link_clk,
    input wire logic        stream_clock_enable,
    input wire logic        word_sync_out,
    input wire logic        frame_sync_out,
    input wire logic        time_sync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Bus and link checks
    // ---------------------------------------------------------------
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence sync_seen;
        frame_sync_out || word_sync_out;
    endsequence
    b_after_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_taken |-> ##2 s_axi_bvalid) else $error("write answer missing");
    b_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    r_after_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer missing");
    r_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    write_blocked_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    read_blocked_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    sync_gated_a: assert property (@(posedge link_clk) disable iff (!aresetn)
        sync_seen |-> stream_clock_enable) else $error("sync while halted");
    frame_pulse_a: assert property (@(posedge link_clk) disable iff (!aresetn)
        frame_sync_out |=> !frame_sync_out [*8]) else $error("frame sync too long");
    word_pulse_a: assert property (@(posedge link_clk) disable iff (!aresetn)
        word_sync_out |=> !word_sync_out [*8]) else $error("word sync too long");
    time_pulse_a: assert property (@(posedge link_clk) disable iff (!aresetn)
        time_sync_out |=> !time_sync_out [*8]) else $error("time sync too long");
endmodule

bind ssc_stream_control ssc_stream_control_asserts chk_u (.*);

// File: dv/ssc_far_end.sv
// Far-side receiver model collecting streamed words
module ssc_far_end (
    input wire logic link_clk,
    input wire logic stream_clock_enable,
    input wire logic stream_data,
    input wire logic word_sync_out,
    input wire logic frame_sync_out,
    input wire integer frame_words
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] shift;
    logic [15:0] words[$];
    int          bit_idx = -1;
    int          ws_count = 0;
    int          ws_bad = 0;
    // Bits only count while the gated clock runs
    always @(posedge link_clk) begin
        if (stream_clock_enable === 1'b1) begin
            if (frame_sync_out === 1'b1) bit_idx = 0;
            if (word_sync_out === 1'b1) begin
                ws_count++;
                if (bit_idx < 0 || bit_idx % 16 != 0) ws_bad++;
            end
            if (bit_idx >= 0 && bit_idx < 16 * frame_words) begin
                shift = {shift[14:0], stream_data};
                if (bit_idx % 16 == 15) words.push_back(shift);
                bit_idx = (bit_idx < 16 * frame_words - 1) ? bit_idx + 1 : -1;
            end
        end
    end
endmodule

// File: dv/tb.sv
// Self-checking bench of the sample stream control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, link_clk, sample_valid;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rdat;
    logic [3:0]  s_axi_wstrb, bypass_sample;
    logic [1:0]  s_axi_bresp, s_axi_rresp, sample_i, sample_q;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, stream_clock_enable, stream_data;
    logic        word_sync_out, frame_sync_out, time_sync_out;
    logic [3:0]  blk [16];
    logic [5:0]  ent [5] = '{6'h3f, 6'h25, 6'h0b, 6'h16, 6'h2c};
    int          frame_words, fail_count, comparisons, cycles, ts_count, n, ts0, ws0;
    localparam logic [5:0] CFG_A = {ssc_pkg::IDX_STREAM_CFG, 2'b00};
    localparam logic [5:0] CHN_A = {ssc_pkg::IDX_CHANNEL_CFG, 2'b00};
    localparam logic [1:0] OK = ssc_pkg::RESP_OKAY;
    ssc_stream_control dut_u (.*);
    ssc_far_end        far_u (.*);
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end
    always @(posedge link_clk) ts_count += (time_sync_out === 1'b1);
    // Ceiling well above the roughly 4200 cycles the sequence needs
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            test_done();
        end
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Entry bits: word pulse, pulse always, insert, quad, select
    function logic [31:0] cfg(input logic [5:0] e, input logic go, hlt, clr);
        return {20'h0_0000, 1'b1, go, hlt, 3'h0, e[1:0], e[3], e[4], e[5], clr};
    endfunction
    // Oldest sample goes out first, so it lands in the top bit
    function logic [15:0] lane_word(input int l);
        for (int k = 0; k < 16; k++) lane_word[15-k] = blk[k][3-l];
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask
    task rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask
    task send_block(input int w);
        for (int k = 0; k < 16; k++) begin
            @(posedge link_clk);
            rdat = rnd();
            blk[k] = rdat[3:0];
            {sample_i, sample_q} <= rdat[3:0];
            sample_valid <= 1'b1;
        end
        @(posedge link_clk);
        sample_valid <= 1'b0;
        repeat (w) @(posedge link_clk);
    endtask
    task test_done();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {sample_i, sample_q, sample_valid, aresetn} = '0;
        {fail_count, comparisons, cycles, ts_count, frame_words} = '0;
        seed = 32'h1411_718d;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CFG_A, ssc_pkg::STREAM_CFG_RESET, OK);
        rd(CHN_A, ssc_pkg::CHANNEL_RESET, OK);
        wr(CHN_A, 32'hffff_ffff, 4'h0, OK);
        rd(CHN_A, 32'h0, OK);
        wr(6'h3c, 32'h1, 4'hf, ssc_pkg::RESP_SLVERR);
        rd(6'h3c, 32'h0, ssc_pkg::RESP_SLVERR);
        repeat (4) begin
            @(posedge link_clk);
            rdat = rnd();
            {sample_i, sample_q, sample_valid} <= {rdat[3:0], 1'b1};
            repeat (2) @(posedge link_clk);
            chk({28'h0, bypass_sample}, {28'h0, rdat[0], rdat[1], rdat[2], rdat[3]});
        end
        @(posedge link_clk);
        sample_valid <= 1'b0;
        foreach (ent[k]) begin
            n = (ent[k][1:0] == 2'h3 && ent[k][2]) ? 4 : 2;
            // Path enable needs link cycles to arrive before the block starts
            wr(CFG_A, cfg(ent[k], 1'b0, 1'b1, 1'b0), 4'hf, OK);
            wr(CHN_A, {31'h0, ent[k][2]}, 4'hf, OK);
            ts0 = ts_count;
            send_block(120);
            chk({31'h0, stream_clock_enable}, 32'h0);
            chk(32'(far_u.words.size()), 32'h0);
            chk(32'(ts_count - ts0), {31'h0, ent[k][4]});
            // Clear with go drops the block held while halted
            wr(CFG_A, cfg(ent[k], 1'b1, 1'b0, 1'b1), 4'hf, OK);
            repeat (12) @(posedge link_clk);
            chk({31'h0, stream_clock_enable}, 32'h1);
            chk({28'h0, bypass_sample}, 32'h0);
            wr(CFG_A, cfg(ent[k], 1'b1, 1'b0, 1'b1), 4'hf, OK);
            repeat (12) @(posedge link_clk);
            frame_words = n + ent[k][3];
            for (int b = 0; b < 2; b++) begin
                {ts0, ws0} = {ts_count, far_u.ws_count};
                send_block(110);
                chk(32'(far_u.words.size()), 32'(frame_words));
                if (ent[k][3]) chk({16'h0, far_u.words.pop_front()}, 32'(b));
                for (int l = 0; l < n; l++)
                    chk({16'h0, far_u.words.pop_front()}, {16'h0, lane_word(l)});
                chk(32'(ts_count - ts0), 32'h1);
                chk(32'(far_u.ws_count - ws0), ent[k][5] ? 32'(n) : 32'h0);
            end
        end
        chk(32'(far_u.ws_bad), 32'h0);
        test_done();
    end
endmodule
